/* core/pfel_map.vh */
// Register map, field positions, reset values and rule overview for the PWM fault and event block
// Overview of operation
// - Unlatched mode reports live trigger state
// - Latched mode reports sticky trigger state
// - Latched triggers stay until individually cleared
// - Status bit one means trigger active
// - Group0 four pins, group1 eight trips
// - Per-group trigger selection, writable and readable
// - Reset uses only external input zero
// - Extended mode uses programmed selection
// - Fault is OR of selected triggers, pins sense-adjusted, trips not
// - Write one clears interrupt status bit
// - Six counter event interrupt sources
// - Raw and masked status both readable
// - Enable bits mask interrupts and triggers
// - Minimum fault period holds fault asserted
// - Per-pin sense, high or low active
`ifndef PFEL_MAP_VH
`define PFEL_MAP_VH
// Per-generator register byte offsets (generator g at g*0x40)
`define PFEL_OFF_CTRL 6'h00
`define PFEL_OFF_SENSE 6'h04
`define PFEL_OFF_MINPER 6'h08
`define PFEL_OFF_SEL0 6'h0C
`define PFEL_OFF_SEL1 6'h10
`define PFEL_OFF_FSTAT0 6'h14
`define PFEL_OFF_FSTAT1 6'h18
`define PFEL_OFF_RIS 6'h1C
`define PFEL_OFF_MIS 6'h20
`define PFEL_OFF_INTEN 6'h24
// Module-level fault event registers, selected by paddr[8]
`define PFEL_OFF_FLT_STS 8'h00
`define PFEL_OFF_FLT_CLR 8'h04
`define PFEL_OFF_FLT_EN 8'h08
// Control field positions
`define PFEL_CTRL_LATCH 0
`define PFEL_CTRL_MINPER 1
`define PFEL_CTRL_EXTSRC 2
// Reset values
`define PFEL_RST_CTRL 3'h0
`define PFEL_RST_SENSE 4'h0
`define PFEL_RST_MINPER 16'h0000
`define PFEL_RST_SEL0 4'h1
`define PFEL_RST_SEL1 8'h00
`define PFEL_RST_INTEN 12'h000
// Legacy source: external input zero only
`define PFEL_LEGACY_SEL0 4'h1
`define PFEL_LEGACY_SEL1 8'h00
`endif

/* core/pfel_core.v */
// PWM fault trigger selection, latching, minimum period and per-generator event interrupt logic
`include "pfel_map.vh"

module pfel_core #(
  parameter NGEN = 4,
  parameter MPW = 16
) (
  // Bus clock, also the PWM clock
  input wire pclk,
  // Asynchronous reset, active low
  input wire presetn,
  // Freezes all state while low
  input wire clk_en,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // External fault pins, asynchronous
  input wire [3:0] ext_fault_in,
  // Comparator trips, eight per generator, same clock
  input wire [8*NGEN-1:0] cmp_trip_in,
  // Counter event pulses, six per generator, same clock
  input wire [6*NGEN-1:0] cnt_evt_in,
  // Generator fault signals
  output reg [NGEN-1:0] gen_fault,
  // Generator interrupt requests
  output reg [NGEN-1:0] gen_irq,
  // Gated converter trigger pulses
  output reg [6*NGEN-1:0] conv_trig,
  // Module fault interrupt
  output reg fault_irq
);

  // Pin synchronisers, first stage read only by second
  reg [3:0] fsync1_ff;
  reg [3:0] fsync2_ff;
  // Module fault event state
  reg [NGEN-1:0] flt_sts_ff;
  reg [NGEN-1:0] flt_en_ff;
  // APB answer registers
  reg [31:0] prdata_ff;
  reg pready_ff;
  reg pslverr_ff;
  reg [31:0] nxt_prdata;
  reg nxt_mapped;

  // Flattened per-generator results
  wire [32*NGEN-1:0] rd_all;
  wire [NGEN-1:0] flt_now;
  wire [NGEN-1:0] flt_rise;
  wire [NGEN-1:0] irq_now;
  wire [6*NGEN-1:0] trig_now;

  // Access phase that completes this edge
  wire acc_done = psel & penable & pready_ff;
  wire wr_acc = acc_done & pwrite;
  // Address decode helpers
  wire up_zero = (paddr[11:9] == 3'h0);
  wire glb_sel = up_zero & paddr[8];
  wire gen_sel = up_zero & ~paddr[8];
  wire [1:0] gidx = paddr[7:6];
  wire [31:0] gen_rd = rd_all[gidx*32 +: 32];
  wire flt_clr_wr = wr_acc & glb_sel & (paddr[7:0] == `PFEL_OFF_FLT_CLR);
  wire flt_en_wr = wr_acc & glb_sel & (paddr[7:0] == `PFEL_OFF_FLT_EN);

  // Two-flop synchroniser for the fault pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsync1_ff <= 4'h0;
      fsync2_ff <= 4'h0;
    end else if (clk_en) begin
      fsync1_ff <= ext_fault_in;
      fsync2_ff <= fsync1_ff;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NGEN; g = g + 1) begin : gen_blk
      // Generator number, sliced to the two index bits where compared
      localparam integer GI = g;
      // Configuration
      reg [2:0] ctrl_ff;
      reg [3:0] sense_ff;
      reg [MPW-1:0] minper_ff;
      reg [3:0] sel0_ff;
      reg [7:0] sel1_ff;
      reg [11:0] inten_ff;
      // Sticky trigger and interrupt state
      reg [3:0] lat0_ff;
      reg [7:0] lat1_ff;
      reg [5:0] ris_ff;
      // Minimum period timer and fault
      reg [MPW-1:0] cnt_ff;
      reg flt_ff;
      reg [31:0] rd_w;

      // Writes aimed at this generator
      wire wr_g = wr_acc & gen_sel & (gidx == GI[1:0]);
      wire ctrl_wr = wr_g & (paddr[5:0] == `PFEL_OFF_CTRL);
      wire sense_wr = wr_g & (paddr[5:0] == `PFEL_OFF_SENSE);
      wire minp_wr = wr_g & (paddr[5:0] == `PFEL_OFF_MINPER);
      wire sel0_wr = wr_g & (paddr[5:0] == `PFEL_OFF_SEL0);
      wire sel1_wr = wr_g & (paddr[5:0] == `PFEL_OFF_SEL1);
      wire fs0_wr = wr_g & (paddr[5:0] == `PFEL_OFF_FSTAT0);
      wire fs1_wr = wr_g & (paddr[5:0] == `PFEL_OFF_FSTAT1);
      wire ris_wr = wr_g & (paddr[5:0] == `PFEL_OFF_RIS);
      wire en_wr = wr_g & (paddr[5:0] == `PFEL_OFF_INTEN);
      wire [3:0] clr0 = fs0_wr ? pwdata[3:0] : 4'h0;
      wire [7:0] clr1 = fs1_wr ? pwdata[7:0] : 8'h00;
      wire [5:0] rclr = ris_wr ? pwdata[5:0] : 6'h00;

      // Sense adjust: sense bit set means active low
      wire [3:0] act0 = fsync2_ff ^ sense_ff;
      // Group one is the eight comparator trips
      wire [7:0] act1 = cmp_trip_in[8*g +: 8];
      wire latch_on = ctrl_ff[`PFEL_CTRL_LATCH];
      // Live state unless latching is on
      // Latched view includes the current cycle
      wire [3:0] st0 = latch_on ? (lat0_ff | act0) : act0;
      wire [7:0] st1 = latch_on ? (lat1_ff | act1) : act1;
      // Legacy mode forces input zero only
      wire [3:0] use0 = ctrl_ff[`PFEL_CTRL_EXTSRC] ? sel0_ff : `PFEL_LEGACY_SEL0;
      wire [7:0] use1 = ctrl_ff[`PFEL_CTRL_EXTSRC] ? sel1_ff : `PFEL_LEGACY_SEL1;
      wire raw_flt = (|(st0 & use0)) | (|(st1 & use1));
      // Hold fault while the timer runs
      wire hold = ctrl_ff[`PFEL_CTRL_MINPER] & (cnt_ff != {MPW{1'b0}});
      wire nxt_flt = raw_flt | hold;
      // Masked status is raw AND enable
      wire [5:0] mis = ris_ff & inten_ff[5:0];

      assign flt_now[g] = nxt_flt;
      assign flt_rise[g] = nxt_flt & ~flt_ff;
      // Request is OR of masked bits
      assign irq_now[g] = |mis;
      assign trig_now[6*g +: 6] = cnt_evt_in[6*g +: 6] & inten_ff[11:6];
      assign rd_all[32*g +: 32] = rd_w;

      // Configuration registers
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl_ff <= `PFEL_RST_CTRL;
          sense_ff <= `PFEL_RST_SENSE;
          minper_ff <= `PFEL_RST_MINPER;
          sel0_ff <= `PFEL_RST_SEL0;
          sel1_ff <= `PFEL_RST_SEL1;
          inten_ff <= `PFEL_RST_INTEN;
        end else if (clk_en) begin
          if (ctrl_wr) begin
            ctrl_ff <= pwdata[2:0];
          end
          if (sense_wr) begin
            sense_ff <= pwdata[3:0];
          end
          if (minp_wr) begin
            minper_ff <= pwdata[MPW-1:0];
          end
          // Selection per group, read back below
          if (sel0_wr) begin
            sel0_ff <= pwdata[3:0];
          end
          if (sel1_wr) begin
            sel1_ff <= pwdata[7:0];
          end
          if (en_wr) begin
            inten_ff <= pwdata[11:0];
          end
        end
      end

      // Sticky trigger, interrupt and timer state
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lat0_ff <= 4'h0;
          lat1_ff <= 8'h00;
          ris_ff <= 6'h00;
          cnt_ff <= {MPW{1'b0}};
          flt_ff <= 1'b0;
        end else if (clk_en) begin
          // Sticky until written one; set beats clear
          if (latch_on) begin
            lat0_ff <= (lat0_ff & ~clr0) | act0;
            lat1_ff <= (lat1_ff & ~clr1) | act1;
          end else begin
            lat0_ff <= 4'h0;
            lat1_ff <= 8'h00;
          end
          // Write one clears, new event wins
          ris_ff <= (ris_ff & ~rclr) | cnt_evt_in[6*g +: 6];
          // Reload while asserted, then count down
          if (raw_flt) begin
            cnt_ff <= minper_ff;
          end else if (cnt_ff != {MPW{1'b0}}) begin
            cnt_ff <= cnt_ff - {{(MPW-1){1'b0}}, 1'b1};
          end
          flt_ff <= nxt_flt;
        end
      end

      // Per-generator read word
      always @* begin
        rd_w = 32'h0000_0000;
        case (paddr[5:0])
          `PFEL_OFF_CTRL: begin
            rd_w[2:0] = ctrl_ff;
          end
          `PFEL_OFF_SENSE: begin
            rd_w[3:0] = sense_ff;
          end
          `PFEL_OFF_MINPER: begin
            rd_w[MPW-1:0] = minper_ff;
          end
          `PFEL_OFF_SEL0: begin
            rd_w[3:0] = sel0_ff;
          end
          `PFEL_OFF_SEL1: begin
            rd_w[7:0] = sel1_ff;
          end
          `PFEL_OFF_FSTAT0: begin
            rd_w[3:0] = st0;
          end
          `PFEL_OFF_FSTAT1: begin
            rd_w[7:0] = st1;
          end
          `PFEL_OFF_RIS: begin
            rd_w[5:0] = ris_ff;
          end
          `PFEL_OFF_MIS: begin
            rd_w[5:0] = mis;
          end
          `PFEL_OFF_INTEN: begin
            rd_w[11:0] = inten_ff;
          end
          default: begin
            rd_w = 32'h0000_0000;
          end
        endcase
      end
    end
  endgenerate

  // Read data and decode of mapped addresses
  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_mapped = 1'b0;
    if (gen_sel) begin
      case (paddr[5:0])
        `PFEL_OFF_CTRL, `PFEL_OFF_SENSE, `PFEL_OFF_MINPER, `PFEL_OFF_SEL0, `PFEL_OFF_SEL1,
        `PFEL_OFF_FSTAT0, `PFEL_OFF_FSTAT1, `PFEL_OFF_RIS, `PFEL_OFF_MIS, `PFEL_OFF_INTEN: begin
          nxt_mapped = 1'b1;
          nxt_prdata = gen_rd;
        end
        default: begin
          nxt_mapped = 1'b0;
        end
      endcase
    end else if (glb_sel) begin
      case (paddr[7:0])
        `PFEL_OFF_FLT_STS: begin
          nxt_mapped = 1'b1;
          nxt_prdata[NGEN-1:0] = flt_sts_ff;
        end
        // Clear register is write-only, reads zero
        `PFEL_OFF_FLT_CLR: begin
          nxt_mapped = 1'b1;
        end
        `PFEL_OFF_FLT_EN: begin
          nxt_mapped = 1'b1;
          nxt_prdata[NGEN-1:0] = flt_en_ff;
        end
        default: begin
          nxt_mapped = 1'b0;
        end
      endcase
    end
  end

  // APB answer: ready in the first access cycle, no wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_ff <= psel & ~penable;
      pslverr_ff <= psel & ~penable & ~nxt_mapped;
      // Data sampled in setup, stable over the access
      if (psel & ~penable & ~pwrite) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // Module fault events: sticky status, write-one clear, enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_sts_ff <= {NGEN{1'b0}};
      flt_en_ff <= {NGEN{1'b0}};
    end else if (clk_en) begin
      // Rising fault beats a simultaneous clear
      flt_sts_ff <= (flt_sts_ff & ~(flt_clr_wr ? pwdata[NGEN-1:0] : {NGEN{1'b0}})) | flt_rise;
      if (flt_en_wr) begin
        flt_en_ff <= pwdata[NGEN-1:0];
      end
    end
  end

  // Registered outputs, one cycle after their cause, gen_irq two cycles after its event
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_fault <= {NGEN{1'b0}};
      gen_irq <= {NGEN{1'b0}};
      conv_trig <= {6*NGEN{1'b0}};
      fault_irq <= 1'b0;
    end else if (clk_en) begin
      gen_fault <= flt_now;
      gen_irq <= irq_now;
      conv_trig <= trig_now;
      fault_irq <= |((flt_sts_ff | flt_rise) & flt_en_ff);
    end
  end

  // Bus outputs mirror their answer flops
  always @* begin
    prdata = prdata_ff;
    pready = pready_ff;
    pslverr = pslverr_ff;
  end

endmodule

/* verif/pfel_core_assertions.sv */
// Checker for the bus answer and event outputs of the fault block
module pfel_core_assertions #(
  parameter NGEN = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [6*NGEN-1:0] cnt_evt_in,
  input wire [NGEN-1:0] gen_fault,
  input wire [NGEN-1:0] gen_irq,
  input wire [6*NGEN-1:0] conv_trig,
  input wire fault_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup phase of a transfer
  sequence setup_s; psel && !penable; endsequence
  // Completing access phase
  sequence done_s; psel && penable && pready; endsequence
  // Zero wait answer, then one cycle only
  ready_after_setup_a: assert property (setup_s |=> pready) else $error("no answer after setup");
  ready_single_a: assert property (done_s |=> !pready) else $error("answer held too long");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("error without answer");
  err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
  trig_needs_event_a: assert property ((conv_trig & ~$past(cnt_evt_in)) == '0)
    else $error("trigger without event");
  // Request moves two edges after its cause: status flop, then output flop
  irq_rise_cause_a: assert property (|(gen_irq & ~$past(gen_irq)) |-> $past(|cnt_evt_in, 2) || $past(pwrite && pready, 2))
    else $error("request rose without cause");
  irq_fall_cause_a: assert property (|($past(gen_irq) & ~gen_irq) |-> $past(pwrite && pready, 2))
    else $error("request fell without clear");
  // Quiet outputs at first edge after release
  reset_quiet_a: assert property ($rose(presetn) |-> gen_irq == '0 && gen_fault == '0 && !pready && !fault_irq)
    else $error("outputs busy after reset");
endmodule
bind pfel_core pfel_core_assertions #(.NGEN(NGEN)) pfel_core_assertions_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .cnt_evt_in, .gen_fault, .gen_irq, .conv_trig, .fault_irq);

/* verif/pfel_core_tb_top.sv */
// Self-checking bench for the fault and event block
`include "pfel_map.vh"
module pfel_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [11:0] paddr = 12'h000;
  logic clk_en = 1'h1;
  logic [31:0] pwdata = 32'h0, rd, trip = 32'h0;
  logic [3:0] ext = 4'h0;
  logic [23:0] evt = 24'h0;
  wire [31:0] prdata;
  wire pready, pslverr, fault_irq;
  wire [3:0] gen_fault, gen_irq;
  wire [23:0] conv_trig;
  int error_cnt = 0, check_count = 0;
  // Clock enable high except for the freeze check at the end
  pfel_core pfel_core_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_fault_in(ext), .cmp_trip_in(trip), .cnt_evt_in(evt), .gen_fault(gen_fault), .gen_irq(gen_irq),
    .conv_trig(conv_trig), .fault_irq(fault_irq));
  initial forever #50 pclk = ~pclk;
  // Register address of generator g
  function automatic logic [11:0] ra(int g, logic [5:0] o);
    return 12'(g * 64) | {6'h00, o};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One transfer; request held until ready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Timed out only if the answer never came
    if (pready !== 1'h1) begin
      error_cnt++;
      test_done();
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Settle outputs after n edges
  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // One-cycle counter event on generator 0
  task automatic pulse(int e, input logic [23:0] exp);
    @(posedge pclk);
    evt <= 24'h1 << e;
    @(posedge pclk);
    evt <= 24'h0;
    #1;
    chk(conv_trig, exp);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    for (int g = 0; g < 4; g++) begin
      rdc(ra(g, `PFEL_OFF_SEL0), 32'h1);
      rdc(ra(g, `PFEL_OFF_CTRL), 32'h0);
    end
    // Hole in the map is refused
    apb(1'h0, 12'h028, 32'h0);
    chk(perr, 1'h1);
    chk(rd, 32'h0);
    apb(1'h1, ra(1, `PFEL_OFF_SEL0), 32'hFFFFFFFF);
    rdc(ra(1, `PFEL_OFF_SEL0), 32'hF);
    apb(1'h1, ra(1, `PFEL_OFF_SEL1), 32'hA5);
    rdc(ra(1, `PFEL_OFF_SEL1), 32'hA5);
    // Legacy source ignores pin 1 and selection
    ext <= 4'h2;
    cyc(4);
    chk(gen_fault, 4'h0);
    @(posedge pclk);
    ext <= 4'h1;
    cyc(4);
    chk(gen_fault, 4'hF);
    rdc(ra(0, `PFEL_OFF_FSTAT0), 32'h1);
    rdc(12'h100, 32'hF);
    apb(1'h1, 12'h108, 32'h1);
    cyc(1);
    chk(fault_irq, 1'h1);
    apb(1'h1, 12'h104, 32'h1);
    rdc(12'h104, 32'h0);
    rdc(12'h100, 32'hE);
    chk(fault_irq, 1'h0);
    // Minimum period holds generator 1 only
    apb(1'h1, ra(1, `PFEL_OFF_MINPER), 32'h5);
    apb(1'h1, ra(1, `PFEL_OFF_CTRL), 32'h2);
    @(posedge pclk);
    ext <= 4'h0;
    cyc(6);
    chk(gen_fault, 4'h2);
    cyc(6);
    chk(gen_fault, 4'h0);
    apb(1'h1, ra(0, `PFEL_OFF_SENSE), 32'h1);
    cyc(4);
    chk(gen_fault[0], 1'h1);
    rdc(ra(0, `PFEL_OFF_FSTAT0), 32'h1);
    // Extended source on comparator trips
    apb(1'h1, ra(2, `PFEL_OFF_CTRL), 32'h4);
    apb(1'h1, ra(2, `PFEL_OFF_SEL1), 32'h80);
    trip <= 32'h0040_0000;
    cyc(3);
    chk(gen_fault[2], 1'h0);
    rdc(ra(2, `PFEL_OFF_FSTAT1), 32'h40);
    trip <= 32'h0080_0000;
    cyc(3);
    chk(gen_fault[2], 1'h1);
    // Latched trip survives its removal
    apb(1'h1, ra(3, `PFEL_OFF_SEL1), 32'h1);
    apb(1'h1, ra(3, `PFEL_OFF_CTRL), 32'h5);
    trip <= 32'h0100_0000;
    @(posedge pclk);
    trip <= 32'h0;
    cyc(3);
    chk(gen_fault[3], 1'h1);
    apb(1'h1, ra(3, `PFEL_OFF_FSTAT1), 32'h0);
    rdc(ra(3, `PFEL_OFF_FSTAT1), 32'h1);
    apb(1'h1, ra(3, `PFEL_OFF_FSTAT1), 32'h1);
    rdc(ra(3, `PFEL_OFF_FSTAT1), 32'h0);
    cyc(2);
    chk(gen_fault[3], 1'h0);
    // All six events: masked, then enabled, then cleared
    for (int e = 0; e < 6; e++) begin
      apb(1'h1, ra(0, `PFEL_OFF_INTEN), 32'h0);
      pulse(e, 24'h0);
      rdc(ra(0, `PFEL_OFF_RIS), 32'h1 << e);
      rdc(ra(0, `PFEL_OFF_MIS), 32'h0);
      chk(gen_irq, 4'h0);
      apb(1'h1, ra(0, `PFEL_OFF_INTEN), 32'h41 << e);
      pulse(e, 24'h1 << e);
      rdc(ra(0, `PFEL_OFF_MIS), 32'h1 << e);
      chk(gen_irq, 4'h1);
      apb(1'h1, ra(0, `PFEL_OFF_RIS), 32'h0);
      rdc(ra(0, `PFEL_OFF_RIS), 32'h1 << e);
      apb(1'h1, ra(0, `PFEL_OFF_RIS), 32'h1 << e);
      rdc(ra(0, `PFEL_OFF_RIS), 32'h0);
      chk(gen_irq, 4'h0);
    end
    // Frozen block ignores a counter event
    @(posedge pclk);
    clk_en <= 1'h0;
    pulse(0, 24'h0);
    @(posedge pclk);
    clk_en <= 1'h1;
    rdc(ra(0, `PFEL_OFF_RIS), 32'h0);
    test_done();
  end
endmodule
